// ===== hdl/reading_filter_map.svh
`ifndef READING_FILTER_MAP_SVH
`define READING_FILTER_MAP_SVH
// ********************************************
// Widths, limits, reset values
// ********************************************
`define RF_READ_W        24
`define RF_SUM_W         32
`define RF_COUNT_MIN     7'h01
`define RF_COUNT_MAX     7'h64
`define RF_RANK_MAX      3'h5
`define RF_NOISE_MAX     7'h69
`define RF_PCT_SCALE     7'h64
`define RF_GROUP_RST     7'h01
`define RF_DEPTH_RST     7'h01
`define RF_RANK_RST      3'h0
`define RF_NOISE_RST     7'h00
`define RF_MED_SLOTS     11
`define RF_MOV_SLOTS     100
`define RF_TBL_SLOTS     8
`define RF_DIV_STEPS     6'h20
`endif

// ===== hdl/reading_filter_pipeline.sv
// Function
// - Group size 1..100, reset value 1
// - Block stage averages group, one output each
// - Block stage disabled passes readings unchanged
// - Rank 0..5, groups of 2n+1 readings
// - Middle stage outputs central ordered reading
// - Middle stage disabled passes readings unchanged
// - Window depth 1..100, reset value 1
// - Full window: drop oldest, average each insert
// - Sliding stage disabled passes readings unchanged
// - Noise window width held 0..105 percent
// - Outside window reading flushes and refills history
// - Noise window ignored while its enable off
// - Auto mode: current settings chosen from range
// - Auto mode voltage: 1, 1, rank 0
// - Auto off: programmed settings everywhere
`timescale 1ns/1ps
`default_nettype none
`include "reading_filter_map.svh"
module reading_filter_pipeline (
   input  wire logic                   sys_clk,
   input  wire logic                   srst,
   input  wire logic                   cfg_load,
   input  wire logic [6:0]             cfg_group_size,
   input  wire logic                   cfg_block_enable,
   input  wire logic [2:0]             cfg_rank,
   input  wire logic                   cfg_middle_enable,
   input  wire logic [6:0]             sliding_mean_depth,
   input  wire logic                   sliding_mean_enable,
   input  wire logic [6:0]             noise_window_percent,
   input  wire logic                   noise_window_enable,
   input  wire logic                   automatic_filter_select,
   input  wire logic                   tbl_wr,
   input  wire logic [2:0]             tbl_index,
   input  wire logic [6:0]             tbl_group,
   input  wire logic [6:0]             tbl_depth,
   input  wire logic [2:0]             tbl_rank,
   input  wire logic                   in_valid,
   output logic                        in_ready,
   input  wire logic [`RF_READ_W-1:0]  in_reading,
   input  wire logic [1:0]             in_func,
   input  wire logic [2:0]             in_range,
   output logic                        out_valid,
   input  wire logic                   out_ready,
   output logic [`RF_READ_W-1:0]       out_reading,
   output logic                        busy
);
   // ********************************************
   // Settings
   // ********************************************
   function automatic logic [6:0] clamp_count(input logic [6:0] c);
      if (c < `RF_COUNT_MIN) begin
         clamp_count = `RF_COUNT_MIN;
      end else if (c > `RF_COUNT_MAX) begin
         clamp_count = `RF_COUNT_MAX;
      end else begin
         clamp_count = c;
      end
   endfunction

   function automatic logic [2:0] clamp_rank(input logic [2:0] r);
      clamp_rank = (r > `RF_RANK_MAX) ? `RF_RANK_MAX : r;
   endfunction

   logic [6:0] group_size;
   logic [6:0] mean_depth;
   logic [2:0] rank;
   logic [6:0] noise_pct;
   logic       block_en;
   logic       middle_en;
   logic       mean_en;
   logic       noise_en;
   logic       auto_sel;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         group_size <= `RF_GROUP_RST;
         mean_depth <= `RF_DEPTH_RST;
         rank       <= `RF_RANK_RST;
         noise_pct  <= `RF_NOISE_RST;
         block_en   <= 1'b0;
         middle_en  <= 1'b0;
         mean_en    <= 1'b0;
         noise_en   <= 1'b0;
         auto_sel   <= 1'b0;
      end else if (cfg_load) begin
         group_size <= clamp_count(cfg_group_size);
         mean_depth <= clamp_count(sliding_mean_depth);
         rank       <= clamp_rank(cfg_rank);
         noise_pct  <= (noise_window_percent > `RF_NOISE_MAX) ? `RF_NOISE_MAX : noise_window_percent;
         block_en   <= cfg_block_enable;
         middle_en  <= cfg_middle_enable;
         mean_en    <= sliding_mean_enable;
         noise_en   <= noise_window_enable;
         auto_sel   <= automatic_filter_select;
      end
   end

   // Current-range table, heavier filtering on the low ranges by default
   logic [6:0] tbl_g [0:`RF_TBL_SLOTS-1];
   logic [6:0] tbl_d [0:`RF_TBL_SLOTS-1];
   logic [2:0] tbl_r [0:`RF_TBL_SLOTS-1];
   genvar gi;
   generate
      for (gi = 0; gi < `RF_TBL_SLOTS; gi++) begin : g_tbl
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               tbl_g[gi] <= 7'(`RF_TBL_SLOTS - gi);
               tbl_d[gi] <= 7'(2 * (`RF_TBL_SLOTS - gi));
               tbl_r[gi] <= (gi < 4) ? 3'h2 : 3'h0;
            end else if (tbl_wr && tbl_index == 3'(gi)) begin
               tbl_g[gi] <= clamp_count(tbl_group);
               tbl_d[gi] <= clamp_count(tbl_depth);
               tbl_r[gi] <= clamp_rank(tbl_rank);
            end
         end
      end
   endgenerate

   // Settings chosen for the incoming reading
   logic [6:0] next_group;
   logic [6:0] next_depth;
   logic [2:0] next_rank;
   always_comb begin
      next_group = group_size;
      next_depth = mean_depth;
      next_rank  = rank;
      if (auto_sel && in_func == reading_filter_pkg::FUNC_CURR) begin
         next_group = tbl_g[in_range];
         next_depth = tbl_d[in_range];
         next_rank  = tbl_r[in_range];
      end else if (auto_sel && in_func == reading_filter_pkg::FUNC_VOLT) begin
         next_group = `RF_COUNT_MIN;
         next_depth = `RF_COUNT_MIN;
         next_rank  = 3'h0;
      end
   end

   // ********************************************
   // Sequencer
   // ********************************************
   reading_filter_pkg::state_t state;
   logic signed [`RF_READ_W-1:0] v;
   logic [6:0]  e_group;
   logic [6:0]  e_depth;
   logic [2:0]  e_rank;
   logic        e_blk;
   logic        e_med;
   logic        e_mov;
   logic        accept;
   logic        flush_hist;
   logic        div_ret_emit;
   logic        div_done;
   logic        buf_ready;
   logic        med_hit;
   logic [3:0]  scan_idx;
   logic [`RF_READ_W-1:0] div_result;
   logic signed [`RF_READ_W-1:0] med_buf [0:`RF_MED_SLOTS-1];

   assign in_ready   = (state == reading_filter_pkg::ST_IDLE);
   assign busy       = !in_ready;
   assign accept     = in_ready && in_valid;
   // Any change of group, depth, rank or stage enables restarts partial groups, so no mixed history
   assign flush_hist = accept && ({next_group, next_depth, next_rank, block_en, middle_en, mean_en}
                       != {e_group, e_depth, e_rank, e_blk, e_med, e_mov});

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         e_group <= `RF_GROUP_RST;
         e_depth <= `RF_DEPTH_RST;
         e_rank  <= `RF_RANK_RST;
         e_blk   <= 1'b0;
         e_med   <= 1'b0;
         e_mov   <= 1'b0;
      end else if (accept) begin
         e_group <= next_group;
         e_depth <= next_depth;
         e_rank  <= next_rank;
         e_blk   <= block_en;
         e_med   <= middle_en;
         e_mov   <= mean_en;
      end
   end

   logic [6:0] blk_cnt;
   logic [3:0] med_cnt;

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state        <= reading_filter_pkg::ST_IDLE;
         v            <= '0;
         div_ret_emit <= 1'b0;
      end else begin
         case (state)
            reading_filter_pkg::ST_IDLE: begin
               if (accept) begin
                  v     <= in_reading;
                  state <= reading_filter_pkg::ST_BLOCK;
               end
            end
            reading_filter_pkg::ST_BLOCK: begin
               if (!e_blk || e_group == `RF_COUNT_MIN) begin
                  state <= reading_filter_pkg::ST_MED;
               end else if (blk_cnt + 7'h01 == e_group) begin
                  div_ret_emit <= 1'b0;
                  state        <= reading_filter_pkg::ST_DIV;
               end else begin
                  state <= reading_filter_pkg::ST_IDLE;
               end
            end
            reading_filter_pkg::ST_DIV: begin
               if (div_done) begin
                  v     <= div_result;
                  state <= div_ret_emit ? reading_filter_pkg::ST_EMIT : reading_filter_pkg::ST_MED;
               end
            end
            reading_filter_pkg::ST_MED: begin
               if (!e_med || e_rank == 3'h0) begin
                  state <= reading_filter_pkg::ST_MOV;
               end else if (med_cnt == {e_rank, 1'b0}) begin
                  state <= reading_filter_pkg::ST_SCAN;
               end else begin
                  state <= reading_filter_pkg::ST_IDLE;
               end
            end
            reading_filter_pkg::ST_SCAN: begin
               if (med_hit) begin
                  v     <= med_buf[scan_idx];
                  state <= reading_filter_pkg::ST_MOV;
               end
            end
            reading_filter_pkg::ST_MOV: begin
               if (!e_mov || e_depth == `RF_COUNT_MIN) begin
                  state <= reading_filter_pkg::ST_EMIT;
               end else begin
                  div_ret_emit <= 1'b1;
                  state        <= reading_filter_pkg::ST_DIV;
               end
            end
            reading_filter_pkg::ST_EMIT: begin
               if (buf_ready) begin
                  state <= reading_filter_pkg::ST_IDLE;
               end
            end
            default: begin
               state <= reading_filter_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // ********************************************
   // Block-averaging stage
   // ********************************************
   logic signed [`RF_SUM_W-1:0] blk_sum;
   always_ff @(posedge sys_clk) begin
      if (srst || flush_hist) begin
         blk_cnt <= '0;
         blk_sum <= '0;
      end else if (state == reading_filter_pkg::ST_BLOCK && e_blk && e_group != `RF_COUNT_MIN) begin
         if (blk_cnt + 7'h01 == e_group) begin
            blk_cnt <= '0;
            blk_sum <= '0;
         end else begin
            blk_cnt <= blk_cnt + 7'h01;
            blk_sum <= blk_sum + `RF_SUM_W'(v);
         end
      end
   end

   // ********************************************
   // Middle-value stage
   // ********************************************
   logic [3:0] lt_cnt;
   logic [3:0] eq_cnt;
   always_comb begin
      lt_cnt = '0;
      eq_cnt = '0;
      for (int k = 0; k < `RF_MED_SLOTS; k++) begin
         if (4'(k) <= {e_rank, 1'b0}) begin
            if (med_buf[k] < med_buf[scan_idx]) begin
               lt_cnt = lt_cnt + 4'h1;
            end
            if (med_buf[k] == med_buf[scan_idx]) begin
               eq_cnt = eq_cnt + 4'h1;
            end
         end
      end
   end
   // Rank counting avoids a sorting network; duplicates still resolve
   assign med_hit = (lt_cnt <= {1'b0, e_rank}) && ({1'b0, e_rank} < lt_cnt + eq_cnt);

   always_ff @(posedge sys_clk) begin
      if (srst || flush_hist) begin
         med_cnt  <= '0;
         scan_idx <= '0;
      end else if (state == reading_filter_pkg::ST_MED && e_med && e_rank != 3'h0) begin
         med_buf[med_cnt] <= v;
         med_cnt          <= (med_cnt == {e_rank, 1'b0}) ? 4'h0 : med_cnt + 4'h1;
         scan_idx         <= '0;
      end else if (state == reading_filter_pkg::ST_SCAN && !med_hit) begin
         scan_idx <= scan_idx + 4'h1;
      end
   end

   // ********************************************
   // Sliding-average stage
   // ********************************************
   logic signed [`RF_READ_W-1:0] mov_buf [0:`RF_MOV_SLOTS-1];
   logic signed [`RF_SUM_W-1:0]  mov_sum;
   logic signed [`RF_READ_W-1:0] mov_avg;
   logic [6:0]  mov_wp;
   logic [6:0]  mov_fill;
   logic signed [`RF_SUM_W-1:0]  next_sum;
   logic [6:0]  next_fill;
   logic [6:0]  next_wp;
   logic [6:0]  wr_slot;
   logic [`RF_READ_W:0] dev_mag;
   logic [`RF_READ_W:0] avg_mag;
   logic        outside;

   always_comb begin
      dev_mag   = (v >= mov_avg) ? (`RF_READ_W+1)'(v - mov_avg) : (`RF_READ_W+1)'(mov_avg - v);
      avg_mag   = mov_avg[`RF_READ_W-1] ? (`RF_READ_W+1)'(-mov_avg) : (`RF_READ_W+1)'(mov_avg);
      outside   = noise_en && mov_fill != 7'h00 &&
                  (33'(dev_mag) * 33'(`RF_PCT_SCALE) > 33'(avg_mag) * 33'(noise_pct));
      wr_slot   = mov_wp;
      next_sum  = mov_sum + `RF_SUM_W'(v);
      next_fill = mov_fill + 7'h01;
      if (outside) begin
         wr_slot   = 7'h00;
         next_sum  = `RF_SUM_W'(v);
         next_fill = 7'h01;
      end else if (mov_fill >= e_depth) begin
         next_sum  = mov_sum + `RF_SUM_W'(v) - `RF_SUM_W'(mov_buf[mov_wp]);
         next_fill = e_depth;
      end
      next_wp = (wr_slot + 7'h01 >= e_depth) ? 7'h00 : wr_slot + 7'h01;
   end

   always_ff @(posedge sys_clk) begin
      if (srst || flush_hist) begin
         mov_sum  <= '0;
         mov_fill <= '0;
         mov_wp   <= '0;
         mov_avg  <= '0;
      end else if (state == reading_filter_pkg::ST_MOV && e_mov && e_depth != `RF_COUNT_MIN) begin
         mov_buf[wr_slot] <= v;
         mov_sum          <= next_sum;
         mov_fill         <= next_fill;
         mov_wp           <= next_wp;
      end else if (state == reading_filter_pkg::ST_DIV && div_done && div_ret_emit) begin
         mov_avg <= div_result; // Baseline for the noise window
      end
   end

   // ********************************************
   // Shared divider, truncates toward zero
   // ********************************************
   logic [`RF_SUM_W-1:0] div_q;
   logic [6:0]  div_rem;
   logic [6:0]  div_den;
   logic [5:0]  div_step;
   logic        div_neg;
   logic [7:0]  rem_sh;
   logic signed [`RF_SUM_W-1:0] start_num;
   logic        div_start;

   assign div_start = (state == reading_filter_pkg::ST_BLOCK && e_blk && e_group != `RF_COUNT_MIN &&
                       blk_cnt + 7'h01 == e_group) ||
                      (state == reading_filter_pkg::ST_MOV && e_mov && e_depth != `RF_COUNT_MIN);
   assign start_num  = (state == reading_filter_pkg::ST_BLOCK) ? blk_sum + `RF_SUM_W'(v) : next_sum;
   assign rem_sh     = {div_rem, div_q[`RF_SUM_W-1]};
   assign div_done   = (div_step == `RF_DIV_STEPS);
   assign div_result = div_neg ? `RF_READ_W'(-div_q) : `RF_READ_W'(div_q);

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         div_q    <= '0;
         div_rem  <= '0;
         div_den  <= `RF_COUNT_MIN;
         div_step <= '0;
         div_neg  <= 1'b0;
      end else if (div_start) begin
         div_q    <= start_num[`RF_SUM_W-1] ? -start_num : start_num;
         div_neg  <= start_num[`RF_SUM_W-1];
         div_den  <= (state == reading_filter_pkg::ST_BLOCK) ? e_group : next_fill;
         div_rem  <= '0;
         div_step <= '0;
      end else if (state == reading_filter_pkg::ST_DIV && !div_done) begin
         if (rem_sh >= {1'b0, div_den}) begin
            div_rem <= 7'(rem_sh - {1'b0, div_den});
            div_q   <= {div_q[`RF_SUM_W-2:0], 1'b1};
         end else begin
            div_rem <= rem_sh[6:0];
            div_q   <= {div_q[`RF_SUM_W-2:0], 1'b0};
         end
         div_step <= div_step + 6'h01;
      end
   end

   // ********************************************
   // Output buffer, receiver stalls hold the sequencer
   // ********************************************
   reading_skid_buffer #(
      .W     (`RF_READ_W),
      .DEPTH (2)
   ) u_out_buf (
      .sys_clk   (sys_clk),
      .srst      (srst),
      .in_valid  (state == reading_filter_pkg::ST_EMIT),
      .in_ready  (buf_ready),
      .in_data   (v),
      .out_valid (out_valid),
      .out_ready (out_ready),
      .out_data  (out_reading)
   );
endmodule // reading_filter_pipeline
`default_nettype wire

// ===== hdl/reading_filter_pkg.sv
package reading_filter_pkg;
   typedef enum logic [1:0] {
      FUNC_VOLT = 2'b00,
      FUNC_CURR = 2'b01,
      FUNC_RES  = 2'b10
   } func_t;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_BLOCK = 3'b001,
      ST_DIV   = 3'b010,
      ST_MED   = 3'b011,
      ST_SCAN  = 3'b100,
      ST_MOV   = 3'b101,
      ST_EMIT  = 3'b110
   } state_t;
endpackage

// ===== hdl/reading_skid_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module reading_skid_buffer #(
   parameter int W     = 24,
   parameter int DEPTH = 2
) (
   input  wire logic         sys_clk,
   input  wire logic         srst,
   input  wire logic         in_valid,
   output logic             in_ready,
   input  wire logic [W-1:0] in_data,
   output logic             out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [0:DEPTH-1];
   logic [AW-1:0] wp;
   logic [AW-1:0] rp;
   logic [AW:0]   fill;
   logic          push;
   logic          pop;

   assign in_ready  = (fill != (AW+1)'(DEPTH));
   assign out_valid = (fill != '0);
   assign out_data  = mem[rp];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem[wp] <= in_data;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wp   <= '0;
         rp   <= '0;
         fill <= '0;
      end else begin
         if (push) begin
            wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + AW'(1);
         end
         if (pop) begin
            rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + AW'(1);
         end
         if (push && !pop) begin
            fill <= fill + (AW+1)'(1);
         end else if (pop && !push) begin
            fill <= fill - (AW+1)'(1);
         end
      end
   end
endmodule // reading_skid_buffer
`default_nettype wire

// ===== verif/reading_filter_pipeline_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "reading_filter_map.svh"
module reading_filter_pipeline_props (
   input wire logic                  sys_clk,
   input wire logic                  srst,
   input wire logic                  in_valid,
   input wire logic                  in_ready,
   input wire logic                  busy,
   input wire logic                  out_valid,
   input wire logic                  out_ready,
   input wire logic [`RF_READ_W-1:0] out_reading
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   // Busy run while the consumer takes; a stalled output may hold EMIT
   logic [7:0] run_cnt;
   always_ff @(posedge sys_clk) begin
      if (srst || !busy || !out_ready) run_cnt <= 8'h00;
      else if (run_cnt != 8'hff) run_cnt <= run_cnt + 8'h01;
   end
   // ****************
   // Checks
   // ****************
   a_wake_ready: assert property ($fell(srst) |-> in_ready && !busy && !out_valid)
      else $error("not idle after reset");
   a_ready_busy: assert property ($rose(busy) |-> $past(in_valid && in_ready))
      else $error("busy started without a taken reading");
   a_take_busy: assert property (in_valid && in_ready |=> busy)
      else $error("accepted reading left no busy");
   a_idle_quiet: assert property (!busy && !in_valid |=> !busy)
      else $error("busy without a reading");
   a_out_cause: assert property ($rose(out_valid) |-> $past(busy))
      else $error("output without processing");
   a_idle_empty: assert property (!busy && !in_valid && !out_valid |=> !out_valid)
      else $error("output from nowhere");
   a_out_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_reading))
      else $error("stalled output changed");
   a_busy_bound: assert property (run_cnt < 8'h96)
      else $error("reading stuck in pipeline");
   c_take: cover property (in_valid && in_ready);
   c_stall: cover property (out_valid && !out_ready ##1 out_valid && out_ready);
   c_long: cover property (busy [*8]);
endmodule // reading_filter_pipeline_props
bind reading_filter_pipeline reading_filter_pipeline_props u_props (
   .sys_clk(sys_clk), .srst(srst), .in_valid(in_valid), .in_ready(in_ready), .busy(busy),
   .out_valid(out_valid), .out_ready(out_ready), .out_reading(out_reading));
`default_nettype wire

// ===== verif/reading_source_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "reading_filter_map.svh"
// ****************
// Converter model
// ****************
module reading_source_model (
   input wire logic                  sys_clk,
   input wire logic                  in_ready,
   output logic                      in_valid,
   output logic [`RF_READ_W-1:0]     in_reading,
   output logic [1:0]                in_func,
   output logic [2:0]                in_range
);
   initial begin
      in_valid = 1'b0;
      in_reading = '0;
      in_func = 2'h0;
      in_range = 3'h0;
   end
   task automatic offer(input logic [23:0] v, input logic [1:0] f, input logic [2:0] r, output bit ok);
      int i;
      @(negedge sys_clk);
      in_valid = 1'b1;
      in_reading = v;
      in_func = f;
      in_range = r;
      ok = 1'b0;
      for (i = 0; i < 400 && !ok; i++) begin
         @(posedge sys_clk);
         ok = (in_ready === 1'b1);
      end
      @(negedge sys_clk);
      in_valid = 1'b0;
      // Released data must not look like a held value
      in_reading = ~v;
   endtask
endmodule // reading_source_model
`default_nettype wire

// ===== verif/test_reading_filter_pipeline.sv
`timescale 1ns/1ps
`default_nettype none
`include "reading_filter_map.svh"
`define CHK(g,e) begin tests_run++; if ((g) !== (e)) begin err_total++; \
   $display("ERROR %0t got %h exp %h", $time, g, e); end end
module test_reading_filter_pipeline;
   logic sys_clk = 1'b0;
   logic srst, cfg_load, cfg_block_enable, cfg_middle_enable, sliding_mean_enable;
   logic noise_window_enable, automatic_filter_select, tbl_wr, in_valid, in_ready;
   logic out_valid, out_ready, busy;
   logic [6:0]            cfg_group_size, sliding_mean_depth, noise_window_percent, tbl_group, tbl_depth;
   logic [2:0]            cfg_rank, tbl_index, tbl_rank, in_range, cur_range;
   logic [1:0]            in_func, cur_func;
   logic [`RF_READ_W-1:0] in_reading, out_reading;
   logic [`RF_READ_W-1:0] got[$];
   int                    err_total, tests_run;
   always #25 sys_clk = ~sys_clk;
   reading_filter_pipeline u_reading_filter_pipeline (
      .sys_clk(sys_clk), .srst(srst), .cfg_load(cfg_load), .cfg_group_size(cfg_group_size),
      .cfg_block_enable(cfg_block_enable), .cfg_rank(cfg_rank), .cfg_middle_enable(cfg_middle_enable),
      .sliding_mean_depth(sliding_mean_depth), .sliding_mean_enable(sliding_mean_enable),
      .noise_window_percent(noise_window_percent), .noise_window_enable(noise_window_enable),
      .automatic_filter_select(automatic_filter_select), .tbl_wr(tbl_wr), .tbl_index(tbl_index),
      .tbl_group(tbl_group), .tbl_depth(tbl_depth), .tbl_rank(tbl_rank), .in_valid(in_valid),
      .in_ready(in_ready), .in_reading(in_reading), .in_func(in_func), .in_range(in_range),
      .out_valid(out_valid), .out_ready(out_ready), .out_reading(out_reading), .busy(busy));
   reading_source_model u_reading_source_model (
      .sys_clk(sys_clk), .in_ready(in_ready), .in_valid(in_valid), .in_reading(in_reading),
      .in_func(in_func), .in_range(in_range));
   always @(posedge sys_clk) begin
      if (out_valid === 1'b1 && out_ready === 1'b1) got.push_back(out_reading);
   end
   // ****************
   // Tasks
   // ****************
   task give_verdict;
      $display("compares %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task fail_out;
      err_total++;
      $display("ERROR %0t wait ran out", $time);
      give_verdict;
   endtask
   task send(input logic [23:0] v);
      bit ok;
      u_reading_source_model.offer(v, cur_func, cur_range, ok);
      if (!ok) fail_out;
   endtask
   task expect_out(input logic [23:0] e);
      int i;
      logic [23:0] g;
      for (i = 0; i < 400 && got.size() == 0; i++) @(negedge sys_clk);
      if (got.size() == 0) fail_out;
      g = got.pop_front();
      `CHK(g, e)
   endtask
   task setc(input logic [6:0] g, input logic be, input logic [2:0] r, input logic me,
             input logic [6:0] d, input logic se, input logic [6:0] p, input logic pe, input logic au);
      @(negedge sys_clk);
      {cfg_group_size, cfg_block_enable, cfg_rank, cfg_middle_enable} = {g, be, r, me};
      {sliding_mean_depth, sliding_mean_enable, noise_window_percent} = {d, se, p};
      {noise_window_enable, automatic_filter_select, cfg_load} = {pe, au, 1'b1};
      @(negedge sys_clk);
      cfg_load = 1'b0;
   endtask
   task done(input string s);
      $display("test %s finished", s);
   endtask
   // ****************
   // Sequence
   // ****************
   initial begin
      {srst, cfg_load, tbl_wr, out_ready} = 4'b1001;
      {cur_func, cur_range, tbl_index, tbl_group, tbl_depth, tbl_rank} = '0;
      {cfg_group_size, cfg_block_enable, cfg_rank, cfg_middle_enable} = {7'h01, 1'b0, 3'h0, 1'b0};
      {sliding_mean_depth, sliding_mean_enable, noise_window_percent} = {7'h01, 1'b0, 7'h00};
      {noise_window_enable, automatic_filter_select} = 2'b00;
      err_total = 0;
      tests_run = 0;
      repeat (4) @(negedge sys_clk);
      srst = 1'b0;
      `CHK({in_ready, busy, out_valid}, 3'b100)
      // Receiver stalls while three readings go through bypassed stages
      out_ready = 1'b0;
      send(24'h00000b);
      send(24'h000016);
      send(24'h000021);
      repeat (8) @(negedge sys_clk);
      `CHK(out_valid, 1'b1)
      out_ready = 1'b1;
      expect_out(24'h00000b);
      expect_out(24'h000016);
      expect_out(24'h000021);
      done("bypass");
      setc(7'h04, 1'b1, 3'h0, 1'b0, 7'h01, 1'b0, 7'h00, 1'b0, 1'b0);
      send(24'h00000a);
      send(24'h000014);
      send(24'h00001e);
      send(24'h000029);
      expect_out(24'h000019);
      repeat (10) @(negedge sys_clk);
      `CHK(got.size(), 0)
      done("block");
      setc(7'h01, 1'b0, 3'h2, 1'b1, 7'h01, 1'b0, 7'h00, 1'b0, 1'b0);
      send(24'h000009);
      send(24'hfffffd);
      send(24'h000007);
      send(24'h000064);
      send(24'h000001);
      expect_out(24'h000007);
      done("middle");
      setc(7'h01, 1'b0, 3'h0, 1'b0, 7'h03, 1'b1, 7'h00, 1'b0, 1'b0);
      send(24'h000003);
      send(24'h000006);
      send(24'h000009);
      send(24'h00000c);
      expect_out(24'h000003);
      expect_out(24'h000004);
      expect_out(24'h000006);
      expect_out(24'h000009);
      done("sliding");
      setc(7'h01, 1'b0, 3'h0, 1'b0, 7'h03, 1'b1, 7'h0a, 1'b1, 1'b0);
      send(24'h000064);
      send(24'h000064);
      send(24'h0000c8);
      expect_out(24'h000064);
      expect_out(24'h000064);
      expect_out(24'h0000c8);
      setc(7'h01, 1'b0, 3'h0, 1'b0, 7'h03, 1'b1, 7'h0a, 1'b0, 1'b0);
      send(24'h000064);
      send(24'h000064);
      send(24'h0000c8);
      // Window enable is not part of the settings compare, so history carries over
      expect_out(24'h000096);
      expect_out(24'h000085);
      expect_out(24'h000085);
      done("noise");
      setc(7'h02, 1'b1, 3'h0, 1'b0, 7'h02, 1'b1, 7'h00, 1'b0, 1'b0);
      send(24'h00000a);
      send(24'h000014);
      send(24'h00001e);
      send(24'h000028);
      expect_out(24'h00000f);
      expect_out(24'h000019);
      done("order");
      setc(7'h04, 1'b1, 3'h0, 1'b0, 7'h01, 1'b0, 7'h00, 1'b0, 1'b1);
      @(negedge sys_clk);
      {tbl_wr, tbl_index, tbl_group, tbl_depth, tbl_rank} = {1'b1, 3'h1, 7'h02, 7'h01, 3'h0};
      @(negedge sys_clk);
      tbl_wr = 1'b0;
      send(24'h000123);
      expect_out(24'h000123);
      {cur_func, cur_range} = {2'h1, 3'h1};
      send(24'h00000a);
      send(24'h00001e);
      expect_out(24'h000014);
      // Lowest current range keeps its reset entry: group of eight
      cur_range = 3'h0;
      for (int k = 0; k < 8; k++) send(24'h000010 + 24'(k));
      expect_out(24'h000013);
      done("auto");
      give_verdict;
   end
endmodule // test_reading_filter_pipeline
`default_nettype wire
